// File: hw/arcs_pkg.sv
// Package for the converter resolution and clock source decode block.
// Assumes an AHB-Lite slave with 32-bit data and single word transfers.
package arcs_pkg;
    localparam logic [7:0] ARCS_OFF_CFG1 = 8'h00;
    localparam logic [7:0] ARCS_OFF_CFG_TWO = 8'h04;
    localparam logic [7:0] ARCS_OFF_CTRL = 8'h08;
    localparam logic [7:0] ARCS_OFF_STAT = 8'h0C;
    localparam int ARCS_CFG1_CLK_LSB = 0;
    localparam int ARCS_CFG1_MODE_LSB = 2;
    localparam int ARCS_CFG_TWO_ACKEN_BIT = 3;
    localparam int ARCS_CTRL_DSEL_BIT = 0;
    localparam int ARCS_CTRL_START_BIT = 1;
    localparam int ARCS_CTRL_STOP_BIT = 2;
    localparam logic [7:0] ARCS_CFG1_RESET = 8'h00;
    localparam logic [7:0] ARCS_CFG_TWO_RESET = 8'h00;
    localparam logic [1:0] ARCS_MODE_8 = 2'h0;
    localparam logic [1:0] ARCS_MODE_12 = 2'h1;
    localparam logic [1:0] ARCS_MODE_10 = 2'h2;
    localparam logic [1:0] ARCS_MODE_16 = 2'h3;
    localparam logic [1:0] ARCS_CLK_BUS = 2'h0;
    localparam logic [1:0] ARCS_CLK_BUS2 = 2'h1;
    localparam logic [1:0] ARCS_CLK_ALT = 2'h2;
    localparam logic [1:0] ARCS_CLK_ASYNC = 2'h3;
    localparam int ARCS_STARTUP_NS = 100;
    localparam int ARCS_CLK_NS = 20;
    localparam int ARCS_STARTUP_CYC_I = (ARCS_STARTUP_NS + ARCS_CLK_NS - 1) / ARCS_CLK_NS;
    localparam logic [7:0] ARCS_STARTUP_CYC = ARCS_STARTUP_CYC_I[7:0];
    typedef enum logic [1:0] {ARCS_IDLE, ARCS_WARM, ARCS_RUN} arcs_state_type;
    typedef struct packed {
        logic [4:0] width;
        logic twos;
    } arcs_fmt_type;
endpackage

// File: hw/arcs_top.sv
// Resolution, result format and conversion clock source decode with register access.
// Assumes a single AHB-Lite master; alternate and async clocks arrive as sampled levels.
// Summary of operation
// - Mode 00 gives 8-bit unsigned single-ended, 9-bit two's complement differential.
// - Mode 01 gives 12-bit single-ended, 13-bit two's complement differential.
// - Mode 10 gives 10-bit single-ended, 11-bit two's complement differential.
// - Mode 11 gives 16-bit both ways, differential in two's complement.
// - Clock code 00 bus clock, 01 bus clock halved, 10 alternate clock.
// - With async clock selected a start is accepted while that clock is off.
// - Async selected and enable clear: clock on at start, off when conversions end.
// - Each on-demand async clock restart waits a startup delay before converting.
// - Async enable bit set keeps async clock and its output running always.
`timescale 1ns/100ps
`default_nettype none
module arcs_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic alternate_clock_input,
    input wire logic async_osc_clock,
    output logic conversion_clock,
    output logic async_clock_run,
    output logic async_conversion_clock,
    output logic conversion_active,
    output logic [4:0] result_width,
    output logic result_twos
);
    logic [7:0] cfg1_ff, nxt_cfg1;
    logic [7:0] cfg_two_ff, nxt_cfg_two;
    logic dsel_ff, nxt_dsel;
    logic wr_ff, nxt_wr;
    logic rd_ff, nxt_rd;
    logic [7:0] addr_ff, nxt_addr;
    logic [31:0] rdata_ff, nxt_rdata;
    logic start_pulse, stop_pulse;
    arcs_pkg::arcs_state_type state_ff, nxt_state;
    logic [7:0] warm_ff, nxt_warm;
    logic div_ff, nxt_div;
    logic cclk_ff, nxt_cclk;
    logic run_ff, nxt_run;
    logic aout_ff, nxt_aout;
    logic act_ff, nxt_act;
    arcs_pkg::arcs_fmt_type fmt_ff, nxt_fmt;
    logic [1:0] input_clock_select;
    logic async_clock_output_enable;
    logic differential_select;

    assign input_clock_select = cfg1_ff[arcs_pkg::ARCS_CFG1_CLK_LSB +: 2];
    assign async_clock_output_enable = cfg_two_ff[arcs_pkg::ARCS_CFG_TWO_ACKEN_BIT];
    assign differential_select = dsel_ff;

    // Bus slave: zero wait states, writes land in the data phase.
    always_comb begin
        nxt_wr = hsel && hready && htrans[1] && hwrite;
        nxt_rd = hsel && hready && htrans[1] && !hwrite;
        nxt_addr = (hsel && hready && htrans[1]) ? haddr[7:0] : addr_ff;
        nxt_cfg1 = cfg1_ff;
        nxt_cfg_two = cfg_two_ff;
        nxt_dsel = dsel_ff;
        start_pulse = 1'b0;
        stop_pulse = 1'b0;
        if (wr_ff) begin
            unique case (addr_ff)
                arcs_pkg::ARCS_OFF_CFG1: nxt_cfg1 = {4'h0, hwdata[3:0]};
                arcs_pkg::ARCS_OFF_CFG_TWO: nxt_cfg_two = {4'h0, hwdata[3], 3'h0};
                arcs_pkg::ARCS_OFF_CTRL: begin
                    nxt_dsel = hwdata[arcs_pkg::ARCS_CTRL_DSEL_BIT];
                    start_pulse = hwdata[arcs_pkg::ARCS_CTRL_START_BIT];
                    stop_pulse = hwdata[arcs_pkg::ARCS_CTRL_STOP_BIT];
                end
                default: ;
            endcase
        end
        nxt_rdata = 32'h0000_0000;
        if (nxt_rd) begin
            unique case (haddr[7:0])
                arcs_pkg::ARCS_OFF_CFG1: nxt_rdata = {24'h0, cfg1_ff};
                arcs_pkg::ARCS_OFF_CFG_TWO: nxt_rdata = {24'h0, cfg_two_ff};
                arcs_pkg::ARCS_OFF_CTRL: nxt_rdata = {31'h0, dsel_ff};
                arcs_pkg::ARCS_OFF_STAT: nxt_rdata = {16'h0, 2'h0, fmt_ff.width, fmt_ff.twos,
                    4'h0, run_ff, act_ff, 2'(state_ff)};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ff <= 1'b0;
            rd_ff <= 1'b0;
            addr_ff <= 8'h00;
            cfg1_ff <= arcs_pkg::ARCS_CFG1_RESET;
            cfg_two_ff <= arcs_pkg::ARCS_CFG_TWO_RESET;
            dsel_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            addr_ff <= nxt_addr;
            cfg1_ff <= nxt_cfg1;
            cfg_two_ff <= nxt_cfg_two;
            dsel_ff <= nxt_dsel;
            rdata_ff <= nxt_rdata;
        end
    end

    assign hrdata = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Result format decode.
    always_comb begin
        nxt_fmt.twos = differential_select;
        unique case (cfg1_ff[arcs_pkg::ARCS_CFG1_MODE_LSB +: 2])
            arcs_pkg::ARCS_MODE_8: nxt_fmt.width = differential_select ? 5'h09 : 5'h08;
            arcs_pkg::ARCS_MODE_12: nxt_fmt.width = differential_select ? 5'h0D : 5'h0C;
            arcs_pkg::ARCS_MODE_10: nxt_fmt.width = differential_select ? 5'h0B : 5'h0A;
            arcs_pkg::ARCS_MODE_16: nxt_fmt.width = 5'h10;
        endcase
    end

    // Conversion sequencing with on-demand async clock.
    always_comb begin
        nxt_state = state_ff;
        nxt_warm = warm_ff;
        unique case (state_ff)
            arcs_pkg::ARCS_IDLE: begin
                if (start_pulse) begin
                    if (input_clock_select == arcs_pkg::ARCS_CLK_ASYNC && !run_ff) begin
                        nxt_state = arcs_pkg::ARCS_WARM;
                        nxt_warm = arcs_pkg::ARCS_STARTUP_CYC;
                    end else begin
                        nxt_state = arcs_pkg::ARCS_RUN;
                    end
                end
            end
            arcs_pkg::ARCS_WARM: begin
                if (stop_pulse) begin
                    nxt_state = arcs_pkg::ARCS_IDLE;
                end else if (warm_ff <= 8'h01) begin
                    nxt_state = arcs_pkg::ARCS_RUN;
                    nxt_warm = 8'h00;
                end else begin
                    nxt_warm = warm_ff - 8'h01;
                end
            end
            arcs_pkg::ARCS_RUN: begin
                if (stop_pulse) begin
                    nxt_state = arcs_pkg::ARCS_IDLE;
                end
            end
            default: nxt_state = arcs_pkg::ARCS_IDLE;
        endcase
        nxt_act = (nxt_state == arcs_pkg::ARCS_RUN);
        nxt_run = async_clock_output_enable
            || (input_clock_select == arcs_pkg::ARCS_CLK_ASYNC
                && nxt_state != arcs_pkg::ARCS_IDLE);
        nxt_aout = nxt_run && async_osc_clock;
        nxt_div = ~div_ff;
        unique case (input_clock_select)
            arcs_pkg::ARCS_CLK_BUS: nxt_cclk = ~cclk_ff;
            arcs_pkg::ARCS_CLK_BUS2: nxt_cclk = div_ff ? ~cclk_ff : cclk_ff;
            arcs_pkg::ARCS_CLK_ALT: nxt_cclk = alternate_clock_input;
            arcs_pkg::ARCS_CLK_ASYNC: nxt_cclk = nxt_run && async_osc_clock;
        endcase
        if (!nxt_act) begin
            nxt_cclk = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= arcs_pkg::ARCS_IDLE;
            warm_ff <= 8'h00;
            div_ff <= 1'b0;
            cclk_ff <= 1'b0;
            run_ff <= 1'b0;
            aout_ff <= 1'b0;
            act_ff <= 1'b0;
            fmt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            warm_ff <= nxt_warm;
            div_ff <= nxt_div;
            cclk_ff <= nxt_cclk;
            run_ff <= nxt_run;
            aout_ff <= nxt_aout;
            act_ff <= nxt_act;
            fmt_ff <= nxt_fmt;
        end
    end

    assign conversion_clock = cclk_ff;
    assign async_clock_run = run_ff;
    assign async_conversion_clock = aout_ff;
    assign conversion_active = act_ff;
    assign result_width = fmt_ff.width;
    assign result_twos = fmt_ff.twos;

    AST_MODE8_WIDTH: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg1_ff[3:2] == 2'h0 |=> result_width == ($past(differential_select) ? 5'h09 : 5'h08))
        else $error("mode 00 width wrong");
    AST_MODE12_WIDTH: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg1_ff[3:2] == 2'h1 |=> result_width == ($past(differential_select) ? 5'h0D : 5'h0C))
        else $error("mode 01 width wrong");
    AST_MODE10_WIDTH: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg1_ff[3:2] == 2'h2 |=> result_width == ($past(differential_select) ? 5'h0B : 5'h0A))
        else $error("mode 10 width wrong");
    AST_MODE16_WIDTH: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg1_ff[3:2] == 2'h3 |=> result_width == 5'h10
        && result_twos == $past(differential_select))
        else $error("mode 11 width wrong");
    AST_ALT_FOLLOW: assert property (@(posedge hclk) disable iff (!hresetn)
        input_clock_select == 2'h2 && nxt_act |=> conversion_clock == $past(alternate_clock_input))
        else $error("alternate clock not routed");
    AST_START_ACCEPT: assert property (@(posedge hclk) disable iff (!hresetn)
        state_ff == arcs_pkg::ARCS_IDLE && start_pulse |=> state_ff != arcs_pkg::ARCS_IDLE)
        else $error("start not accepted");
    AST_ASYNC_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        !async_clock_output_enable && state_ff == arcs_pkg::ARCS_IDLE
        && $past(state_ff == arcs_pkg::ARCS_IDLE) && $past(!async_clock_output_enable)
        |-> !async_clock_run)
        else $error("async clock left running");
    AST_WARM_DELAY: assert property (@(posedge hclk) disable iff (!hresetn)
        state_ff == arcs_pkg::ARCS_IDLE && start_pulse && input_clock_select == 2'h3
        && !run_ff && !async_clock_output_enable
        |=> !conversion_active [*5])
        else $error("no startup delay");
    AST_ENABLE_RUN: assert property (@(posedge hclk) disable iff (!hresetn)
        async_clock_output_enable |=> async_clock_run)
        else $error("async clock not forced on");
    AST_ASYNC_SEL: assert property (@(posedge hclk) disable iff (!hresetn)
        input_clock_select == 2'h3 && $past(input_clock_select) == 2'h3
        && conversion_active |-> async_clock_run)
        else $error("async clock not running while selected");
    COV_WARM: cover property (@(posedge hclk) disable iff (!hresetn)
        state_ff == arcs_pkg::ARCS_WARM ##1 state_ff == arcs_pkg::ARCS_RUN);
    COV_TWOS16: cover property (@(posedge hclk) disable iff (!hresetn)
        result_width == 5'h10 && result_twos);
    COV_ALT_RUN: cover property (@(posedge hclk) disable iff (!hresetn)
        conversion_active && input_clock_select == 2'h2);
endmodule // arcs_top
`default_nettype wire

// File: verif/test_arcs_top.sv
// Self-checking bench for the resolution and clock source decode block.
// Assumes the one AHB-Lite slave answers with zero wait states and OKAY.
`timescale 1ns/100ps
`default_nettype none
module test_arcs_top;
    logic hclk, hresetn, hsel, hwrite, osc, alt, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd_q, rd;
    logic [1:0] htrans;
    logic [2:0] hsize, alt_cnt;
    logic conversion_clock, async_clock_run, async_conversion_clock, conversion_active;
    logic [4:0] result_width;
    logic result_twos;
    int num_errors, total_checks, n, t;
    arcs_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .alternate_clock_input(alt),
        .async_osc_clock(osc), .conversion_clock(conversion_clock),
        .async_clock_run(async_clock_run), .async_conversion_clock(async_conversion_clock),
        .conversion_active(conversion_active), .result_width(result_width),
        .result_twos(result_twos));
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    // Oscillator toggles each cycle, the alternate clock every four cycles.
    always @(posedge hclk) begin
        rd_q <= hrdata;
        osc <= ~osc;
        alt_cnt <= alt_cnt + 3'h1;
        if (alt_cnt[1:0] == 2'h3) begin
            alt <= ~alt;
        end
    end
    task finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask
    task wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin
            num_errors++;
            finish_test();
        end
    endtask
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_ready();
        #1 rd = rd_q;
        chk("hresp", 32'h0, {31'h0, hresp});
        chk("hreadyout", 32'h1, {31'h0, hreadyout});
    endtask
    task toggles(output int c);
        logic p;
        c = 0;
        #1 p = conversion_clock;
        repeat (8) begin
            @(posedge hclk);
            #1 c += (conversion_clock != p);
            p = conversion_clock;
        end
    endtask
    task wait_active(output int c);
        c = 0;
        while (conversion_active !== 1'b1 && c < 20) begin
            @(posedge hclk);
            #1 c++;
        end
        if (c >= 20) begin
            num_errors++;
            finish_test();
        end
    endtask
    initial begin
        {hsel, hwrite, osc, alt, alt_cnt, haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        hresetn = 1'b0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, arcs_pkg::ARCS_OFF_CFG1, 32'h0);
        chk("cfg1", {24'h0, arcs_pkg::ARCS_CFG1_RESET}, rd);
        xfer(1'b1, 8'h10, 32'hFFFFFFFF);
        xfer(1'b0, 8'h10, 32'h0);
        chk("unmapped", 32'h0, rd);
        for (int m = 0; m < 4; m++) begin
            for (int d = 0; d < 2; d++) begin
                xfer(1'b1, arcs_pkg::ARCS_OFF_CTRL, d);
                xfer(1'b1, arcs_pkg::ARCS_OFF_CFG1, m << 2);
                repeat (3) @(posedge hclk);
                n = (m == 0) ? 8 : (m == 1) ? 12 : (m == 2) ? 10 : 16;
                n = (m == 3) ? 16 : n + d;
                #1 chk("width", n, result_width);
                chk("twos", d, result_twos);
                xfer(1'b0, arcs_pkg::ARCS_OFF_STAT, 32'h0);
                chk("stat fmt", {n[4:0], d[0]}, rd[13:8]);
            end
        end
        for (int c = 0; c < 3; c++) begin
            xfer(1'b1, arcs_pkg::ARCS_OFF_CFG1, c);
            xfer(1'b1, arcs_pkg::ARCS_OFF_CTRL, 32'h2);
            repeat (3) @(posedge hclk);
            toggles(t);
            chk("clock toggles", (c == 0) ? 8 : (c == 1) ? 4 : 2, t);
            xfer(1'b1, arcs_pkg::ARCS_OFF_CTRL, 32'h4);
            repeat (3) @(posedge hclk);
            #1 chk("idle clock", 32'h0, {conversion_active, conversion_clock});
        end
        xfer(1'b1, arcs_pkg::ARCS_OFF_CFG1, 32'h3);
        repeat (2) begin
            xfer(1'b1, arcs_pkg::ARCS_OFF_CTRL, 32'h2);
            wait_active(n);
            chk("async run", 32'h1, async_clock_run);
            chk("startup wait", 32'h1, n >= arcs_pkg::ARCS_STARTUP_CYC_I - 1);
            chk("startup bound", 32'h1, n <= arcs_pkg::ARCS_STARTUP_CYC_I + 3);
            toggles(t);
            chk("async toggles", 32'h8, t);
            chk("async out", {31'h0, ~osc}, {31'h0, async_conversion_clock});
            xfer(1'b1, arcs_pkg::ARCS_OFF_CTRL, 32'h4);
            repeat (3) @(posedge hclk);
            #1 chk("async off", 32'h0, {async_clock_run, async_conversion_clock});
        end
        xfer(1'b1, arcs_pkg::ARCS_OFF_CFG_TWO, 32'h8);
        xfer(1'b0, arcs_pkg::ARCS_OFF_CFG_TWO, 32'h0);
        chk("config two", 32'h8, rd);
        repeat (3) @(posedge hclk);
        #1 chk("idle run", 32'h1, async_clock_run);
        chk("idle async out", {31'h0, ~osc}, {31'h0, async_conversion_clock});
        xfer(1'b1, arcs_pkg::ARCS_OFF_CTRL, 32'h2);
        wait_active(n);
        chk("warm start", 32'h1, n <= 2);
        xfer(1'b1, arcs_pkg::ARCS_OFF_CTRL, 32'h4);
        repeat (3) @(posedge hclk);
        #1 chk("kept run", 32'h1, async_clock_run);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        #1 chk("reset run", 32'h0, {async_clock_run, conversion_active});
        chk("reset width", 32'h0, result_width);
        @(posedge hclk);
        hresetn <= 1'b1;
        xfer(1'b0, arcs_pkg::ARCS_OFF_CFG_TWO, 32'h0);
        chk("config two reset", {24'h0, arcs_pkg::ARCS_CFG_TWO_RESET}, rd);
        finish_test();
    end
endmodule // test_arcs_top
`default_nettype wire
